// >>> hdl/omg_params.svh
// Constants for the oscillator monitor and drive gating block
`ifndef OMG_PARAMS_SVH
`define OMG_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define OMG_CLK_MHZ 10
`define OMG_LF_MAX_NS 1500
`define OMG_LF_CYC ((`OMG_LF_MAX_NS * `OMG_CLK_MHZ) / 1000)
`define OMG_HF_MIN_NS 300
`define OMG_HF_CYC ((`OMG_HF_MIN_NS * `OMG_CLK_MHZ + 999) / 1000)
`define OMG_RELAX_NS 10000
`define OMG_RELAX_CYC ((`OMG_RELAX_NS * `OMG_CLK_MHZ) / 1000)
`define OMG_CNT_W 12

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OMG_ADDR_W 5
`define OMG_OFS_CTRL 5'h00
`define OMG_OFS_FILT 5'h04
`define OMG_OFS_STATUS 5'h08
`define OMG_OFS_MASK 5'h0C
`define OMG_OFS_STATE 5'h10

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define OMG_ACT_RESET 3'h0
`define OMG_ACT_DRV_OFF 3'h0
`define OMG_ACT_PUMP_OFF 3'h1
`define OMG_ACT_BOTH_OFF 3'h2
`define OMG_ACT_LATCHED 3'h3
`define OMG_ACT_NODET_BIT 2
`define OMG_FILT_RESET 8'h04
`define OMG_STAT_W 4
`define OMG_STAT_LOW 0
`define OMG_STAT_HIGH 1
`define OMG_STAT_ALARM 2
`define OMG_STAT_UV 3
`define OMG_MASK_RESET 4'h0
`define OMG_RESP_OKAY 2'h0
`define OMG_RESP_SLVERR 2'h2

`endif

// >>> hdl/omg_pkg.sv
// Types shared by the oscillator monitor and drive gating block
package omg_pkg;

    // Gate drive requests and enables, one bit per pre-driver
    typedef struct packed {
        logic supply_relay;
        logic motor_relay;
        logic phase_w;
        logic phase_v;
        logic phase_u;
    } omg_gate_t;

    // Sticky event bits, same layout for status and mask
    typedef struct packed {
        logic undervoltage;
        logic alarm;
        logic freq_high_flag;
        logic freq_low_flag;
    } omg_status_t;

endpackage

// >>> hdl/omg_top.sv
// Oscillator frequency monitor with pre-driver and charge-pump gating, AXI4-Lite registers
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "omg_params.svh"

// Summary of operation
// - Overdue monitor restart flags low frequency fault
// - Monitor still high at falling edge: high
// - Host selects one of five fault actions
// - New action applies only after faults cleared
// - Action 1xx disables frequency fault detection
// - Action 011 keeps circuits off until clear
// - Actions 000-010 recover when fault ends
// - Clearing both flags restores circuits, diag high
// - Any alarm low disables all pre-drivers
// - Alarms high: each driver follows own request
// - Alarm inputs pass a programmable noise filter
// - Filtered alarm low enables short detection
// - Power-good low forces all gate enables low
// - Pump enable pin low disables charge pump
// - Pump needs pin, power-good and request
// - Pump switch follows pin and power-good only
// - Undervoltage after relaxation drops power-good
module omg_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`OMG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`OMG_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic divided_monitor_clock,
    input wire logic alarm_in_a,
    input wire logic alarm_in_b,
    input wire logic pump_enable_pin,
    input wire logic undervoltage_in,
    input wire omg_pkg::omg_gate_t drive_request,
    input wire logic pump_internal_request,
    output omg_pkg::omg_gate_t gate_enable,
    output logic short_detect_enable,
    output logic pump_enable_internal,
    output logic pump_switch_circuit,
    output logic osc_enable,
    output logic diag_out_n,
    output logic irq
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    omg_pkg::omg_gate_t req_a;
    omg_pkg::omg_gate_t req_b;
    logic mon_clk;
    logic alarm_a_raw;
    logic alarm_b_raw;
    logic pump_pin;
    logic uv_raw;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
            req_a <= '0;
            req_b <= '0;
        end else begin
            sync_a <= {divided_monitor_clock, alarm_in_a, alarm_in_b, pump_enable_pin, undervoltage_in, 1'b0};
            sync_b <= sync_a;
            req_a <= drive_request;
            req_b <= req_a;
        end
    end

    assign mon_clk = sync_b[5];
    assign alarm_a_raw = sync_b[4];
    assign alarm_b_raw = sync_b[3];
    assign pump_pin = sync_b[2];
    assign uv_raw = sync_b[1];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [2:0] action_setting;
    logic [2:0] action_active;
    logic [7:0] filt_time;
    omg_pkg::omg_status_t status;
    omg_pkg::omg_status_t mask;

    // ----------------------------------------------------------------
    // Alarm noise filters
    // ----------------------------------------------------------------
    logic [7:0] filt_cnt_a;
    logic [7:0] filt_cnt_b;
    logic alarm_a;
    logic alarm_b;

    // Output follows the input once it has differed for filt_time + 1 cycles
    function automatic logic [7:0] filt_step(input logic raw, cur, input logic [7:0] cnt, lim);
        filt_step = (raw == cur || cnt >= lim) ? 8'h00 : cnt + 8'h01;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_cnt_a <= 8'h00;
            filt_cnt_b <= 8'h00;
            alarm_a <= 1'b0;
            alarm_b <= 1'b0;
        end else begin
            filt_cnt_a <= filt_step(alarm_a_raw, alarm_a, filt_cnt_a, filt_time);
            filt_cnt_b <= filt_step(alarm_b_raw, alarm_b, filt_cnt_b, filt_time);
            alarm_a <= (filt_cnt_a >= filt_time) ? alarm_a_raw : alarm_a;
            alarm_b <= (filt_cnt_b >= filt_time) ? alarm_b_raw : alarm_b;
        end
    end

    // ----------------------------------------------------------------
    // Supply undervoltage and power-good
    // ----------------------------------------------------------------
    logic [`OMG_CNT_W-1:0] relax_cnt;
    logic power_good;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            relax_cnt <= '0;
            power_good <= 1'b0;
        end else if (!uv_raw) begin
            relax_cnt <= '0;
            power_good <= 1'b1;
        end else if (relax_cnt >= `OMG_CNT_W'(`OMG_RELAX_CYC - 1)) begin
            power_good <= 1'b0;
        end else begin
            relax_cnt <= relax_cnt + `OMG_CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Frequency monitor
    // ----------------------------------------------------------------
    logic mon_clk_d;
    logic [7:0] period_cnt;
    logic overdue;
    logic live_low;
    logic live_high;
    logic low_event;
    logic high_event;
    logic detect_on;

    assign detect_on = !action_active[`OMG_ACT_NODET_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_clk_d <= 1'b0;
            period_cnt <= 8'h00;
            overdue <= 1'b0;
            live_low <= 1'b0;
            live_high <= 1'b0;
            low_event <= 1'b0;
            high_event <= 1'b0;
        end else begin
            mon_clk_d <= mon_clk;
            low_event <= 1'b0;
            high_event <= 1'b0;
            if (mon_clk && !mon_clk_d) begin
                // Comparator input is restarted each monitor period
                period_cnt <= 8'h00;
                overdue <= 1'b0;
                live_low <= overdue && detect_on;
                low_event <= overdue && detect_on;
            end else begin
                period_cnt <= period_cnt + {7'h00, period_cnt != 8'hFF};
                overdue <= overdue || period_cnt >= 8'(`OMG_LF_CYC - 1);
            end
            if (!mon_clk && mon_clk_d) begin
                // Too short a high phase means the comparator never dropped
                live_high <= (period_cnt < 8'(`OMG_HF_CYC)) && detect_on;
                high_event <= (period_cnt < 8'(`OMG_HF_CYC)) && detect_on;
            end
            if (!detect_on) begin
                live_low <= 1'b0;
                live_high <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [`OMG_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_status;
    logic [`OMG_STAT_W-1:0] clr_bits;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_status = do_write && aw_addr == `OMG_OFS_STATUS && w_strb[0];
    assign clr_bits = wr_status ? w_data[`OMG_STAT_W-1:0] : '0;

    function automatic logic addr_known(input logic [`OMG_ADDR_W-1:0] a);
        addr_known = a == `OMG_OFS_CTRL || a == `OMG_OFS_FILT || a == `OMG_OFS_STATUS ||
            a == `OMG_OFS_MASK || a == `OMG_OFS_STATE;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OMG_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_known(aw_addr) ? `OMG_RESP_OKAY : `OMG_RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            action_setting <= `OMG_ACT_RESET;
            filt_time <= `OMG_FILT_RESET;
            mask <= `OMG_MASK_RESET;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                `OMG_OFS_CTRL: action_setting <= w_data[2:0];
                `OMG_OFS_FILT: filt_time <= w_data[7:0];
                `OMG_OFS_MASK: mask <= w_data[`OMG_STAT_W-1:0];
                default: ;
            endcase
        end
    end

    // Read channel
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `OMG_OFS_CTRL: rd_word[2:0] = action_setting;
            `OMG_OFS_FILT: rd_word[7:0] = filt_time;
            `OMG_OFS_STATUS: rd_word[`OMG_STAT_W-1:0] = status;
            `OMG_OFS_MASK: rd_word[`OMG_STAT_W-1:0] = mask;
            `OMG_OFS_STATE: rd_word[10:0] = {live_high, live_low, alarm_b, alarm_a, power_good,
                diag_out_n, 2'h0, action_active};
            default: ;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `OMG_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= addr_known(s_axi_araddr) ? `OMG_RESP_OKAY : `OMG_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sticky status, fault flags and interrupt
    // ----------------------------------------------------------------
    omg_pkg::omg_status_t set_bits;
    omg_pkg::omg_status_t next_status;

    always_comb begin
        set_bits.freq_low_flag = low_event;
        set_bits.freq_high_flag = high_event;
        set_bits.alarm = !alarm_a || !alarm_b;
        set_bits.undervoltage = !power_good;
        // A live fault blocks its clear; a set wins over a clear
        next_status = status & ~(clr_bits & ~{1'b0, 1'b0, live_high, live_low});
        next_status = next_status | set_bits;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= '0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= |(next_status & mask);
        end
    end

    // ----------------------------------------------------------------
    // Fault action and shutdown
    // ----------------------------------------------------------------
    logic flags_set;
    logic fault_live;
    logic drv_off;
    logic pump_off;

    assign flags_set = status.freq_low_flag || status.freq_high_flag;
    assign fault_live = live_low || live_high;

    // Setting adopted only with no live fault and both flags clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            action_active <= `OMG_ACT_RESET;
        end else if (!fault_live && !flags_set) begin
            action_active <= action_setting;
        end
    end

    always_comb begin
        drv_off = 1'b0;
        pump_off = 1'b0;
        case (action_active)
            `OMG_ACT_DRV_OFF: drv_off = fault_live;
            `OMG_ACT_PUMP_OFF: pump_off = fault_live;
            `OMG_ACT_BOTH_OFF: begin
                drv_off = fault_live;
                pump_off = fault_live;
            end
            `OMG_ACT_LATCHED: begin
                drv_off = fault_live || flags_set;
                pump_off = fault_live || flags_set;
            end
            default: drv_off = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Gate, pump and diagnostic outputs
    // ----------------------------------------------------------------
    omg_pkg::omg_gate_t next_gate;
    logic alarms_ok;

    assign alarms_ok = alarm_a && alarm_b;

    assign next_gate = (!alarms_ok || !power_good || drv_off) ? '0 : req_b;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_enable <= '0;
            short_detect_enable <= 1'b0;
            pump_enable_internal <= 1'b0;
            pump_switch_circuit <= 1'b0;
            osc_enable <= 1'b0;
            diag_out_n <= 1'b0;
        end else begin
            gate_enable <= next_gate;
            short_detect_enable <= !alarms_ok;
            pump_enable_internal <= pump_pin && power_good && pump_internal_request && !pump_off;
            pump_switch_circuit <= pump_pin && power_good;
            osc_enable <= power_good;
            diag_out_n <= power_good && !(next_status.freq_low_flag || next_status.freq_high_flag);
        end
    end

endmodule
`default_nettype wire

// >>> bench/omg_top_chk.sv
// Concurrent checks on the ports of the monitor and gating block
`timescale 1ns/1ns
`default_nettype none

module omg_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pump_enable_pin,
    input wire logic undervoltage_in,
    input wire omg_pkg::omg_gate_t drive_request,
    input wire logic pump_internal_request,
    input wire omg_pkg::omg_gate_t gate_enable,
    input wire logic short_detect_enable,
    input wire logic pump_enable_internal,
    input wire logic pump_switch_circuit,
    input wire logic osc_enable,
    input wire logic diag_out_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------
    // Undervoltage run length
    // ------------------------------------------------
    // Saturates so a long brown-out cannot wrap
    logic [7:0] uv_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || !undervoltage_in) begin
            uv_cnt <= 8'h00;
        end else if (uv_cnt != 8'hC8) begin
            uv_cnt <= uv_cnt + 8'h01;
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    a_alarm_blocks: assert property (short_detect_enable |-> gate_enable == '0)
        else $error("gate enable high while an alarm is filtered low");
    a_pg_blocks: assert property (!osc_enable |-> gate_enable == '0 && !pump_enable_internal && !diag_out_n)
        else $error("output active while power-good low");
    a_gate_follows: assert property (gate_enable != '0 |-> (gate_enable & ~$past(drive_request, 3)) == '0)
        else $error("gate enable without its own request");
    a_pump_needs: assert property (pump_enable_internal |-> $past(pump_enable_pin, 3) && $past(pump_internal_request)
        && osc_enable)
        else $error("pump enabled without pin, request and power-good");
    a_switch_follows: assert property ($stable(osc_enable) |-> pump_switch_circuit ==
        ($past(pump_enable_pin, 3) && osc_enable))
        else $error("pump switch not following pin and power-good");
    a_uv_drop: assert property (uv_cnt == 8'h6E |-> !osc_enable)
        else $error("power-good still high after relaxation delay");
    a_uv_late: assert property ($fell(osc_enable) |-> uv_cnt >= 8'h64)
        else $error("power-good dropped before relaxation delay");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp))
        else $error("read data changed before rready");
endmodule

bind omg_top omg_chk u_chk (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pump_enable_pin, .undervoltage_in, .drive_request,
    .pump_internal_request, .gate_enable, .short_detect_enable, .pump_enable_internal, .pump_switch_circuit,
    .osc_enable, .diag_out_n);

`default_nettype wire

// >>> bench/omg_osc_src.sv
// Divided monitor clock source standing in for the oscillator divider
`timescale 1ns/1ns
`default_nettype none

module omg_osc_src (
    input wire logic aclk,
    input wire logic [1:0] mode,
    output logic divided_monitor_clock = 1'b0
);
    // Mode 0 nominal, 1 stretches the low phase past the limit, 2 shortens the high phase
    logic [3:0] phase = 4'h0;
    always @(posedge aclk) begin
        phase <= (mode != 2'h1 && phase == 4'h9) ? 4'h0 : phase + 4'h1;
        case (mode)
            2'h2: divided_monitor_clock <= (phase < 4'h2);
            default: divided_monitor_clock <= (phase < 4'h5);
        endcase
    end
endmodule

`default_nettype wire

// >>> bench/osc_monitor_and_drive_gating_bench.sv
// Self-checking bench for the monitor and gating block
`timescale 1ns/1ns
`default_nettype none
`include "omg_params.svh"

module osc_monitor_and_drive_gating_bench;
    typedef struct packed {
        logic [31:0] m;
        logic [31:0] e;
        logic [1:0] r;
    } omg_rexp_t;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00;
    logic [2:0] s_axi_awprot = 3'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [4:0] s_axi_araddr = 5'h00;
    logic [2:0] s_axi_arprot = 3'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic divided_monitor_clock;
    logic alarm_in_a = 1'b1;
    logic alarm_in_b = 1'b1;
    logic pump_enable_pin = 1'b1;
    logic undervoltage_in = 1'b0;
    omg_pkg::omg_gate_t drive_request = '0;
    logic pump_internal_request = 1'b1;
    omg_pkg::omg_gate_t gate_enable;
    logic short_detect_enable;
    logic pump_enable_internal;
    logic pump_switch_circuit;
    logic osc_enable;
    logic diag_out_n;
    logic irq;
    logic [1:0] osc_mode = 2'h0;
    logic probe = 1'b0;
    logic [4:0] g;
    omg_rexp_t re;
    logic [1:0] bq[$];
    omg_rexp_t rq[$];
    logic [9:0] pq[$];
    int n_mismatch = 0;
    int n_tests = 0;
    localparam logic [9:0] RUN_OK = {5'h1F, 5'h1A};

    always #50 aclk = ~aclk;

    omg_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .divided_monitor_clock, .alarm_in_a, .alarm_in_b, .pump_enable_pin, .undervoltage_in, .drive_request,
        .pump_internal_request, .gate_enable, .short_detect_enable, .pump_enable_internal, .pump_switch_circuit,
        .osc_enable, .diag_out_n, .irq);

    omg_osc_src osc_src (.aclk, .mode(osc_mode), .divided_monitor_clock);

    // ------------------------------------------------
    // Comparison, bus tasks and the monitor
    // ------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw = 1'b0;
        logic w = 1'b0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!(aw && w));
        // bready rises in the same cycle as bvalid, so the response is never held
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
        rq.push_back('{m, e, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // Samples gates and flags one edge after n cycles
    task automatic pins(input int n, input logic [9:0] e);
        repeat (n) @(posedge aclk);
        pq.push_back(e);
        probe <= 1'b1;
        @(posedge aclk);
        probe <= 1'b0;
    endtask

    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
        if (s_axi_rvalid && s_axi_rready) begin
            re = rq.pop_front();
            chk(s_axi_rdata & re.m, re.e);
            chk(s_axi_rresp, re.r);
        end
        if (probe) chk({gate_enable, pump_enable_internal, pump_switch_circuit, short_detect_enable, diag_out_n,
            irq}, pq.pop_front());
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        n_mismatch++;
        close_out();
    end

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial begin
        void'($urandom(32'hC731A2EB));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(`OMG_OFS_CTRL, 32'hFFFFFFFF, 32'h0, `OMG_RESP_OKAY);
        rd(`OMG_OFS_FILT, 32'hFF, {24'h0, `OMG_FILT_RESET}, `OMG_RESP_OKAY);
        rd(`OMG_OFS_MASK, 32'hF, 32'h0, `OMG_RESP_OKAY);
        rd(5'h14, 32'hFFFFFFFF, 32'h0, `OMG_RESP_SLVERR);
        wr(5'h14, 32'hFF, `OMG_RESP_SLVERR);
        wr(`OMG_OFS_STATUS, 32'hF, `OMG_RESP_OKAY);
        rd(`OMG_OFS_STATUS, 32'hF, 32'h0, `OMG_RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            g = 5'($urandom_range(31));
            drive_request <= omg_pkg::omg_gate_t'(g);
            pins(4, {g, 5'h1A});
        end
        drive_request <= omg_pkg::omg_gate_t'(5'h1F);
        alarm_in_a <= 1'b0;
        pins(12, {5'h00, 5'h1E});
        wr(`OMG_OFS_MASK, 32'h4, `OMG_RESP_OKAY);
        pins(2, {5'h00, 5'h1F});
        alarm_in_a <= 1'b1;
        alarm_in_b <= 1'b0;
        pins(12, {5'h00, 5'h1F});
        alarm_in_b <= 1'b1;
        pins(12, {5'h1F, 5'h1B});
        wr(`OMG_OFS_STATUS, 32'h4, `OMG_RESP_OKAY);
        pins(2, RUN_OK);
        wr(`OMG_OFS_MASK, 32'h0, `OMG_RESP_OKAY);
        wr(`OMG_OFS_FILT, 32'h14, `OMG_RESP_OKAY);
        alarm_in_a <= 1'b0;
        pins(9, RUN_OK);
        pins(20, {5'h00, 5'h1E});
        alarm_in_a <= 1'b1;
        pins(26, RUN_OK);
        for (int i = 0; i < 4; i++) begin
            pump_enable_pin <= i[1];
            pump_internal_request <= i[0];
            pins(4, {5'h1F, i[1] & i[0], i[1], 3'h2});
        end
        undervoltage_in <= 1'b1;
        pins(50, RUN_OK);
        pins(70, 10'h000);
        undervoltage_in <= 1'b0;
        repeat (10) @(posedge aclk);
        wr(`OMG_OFS_STATUS, 32'hF, `OMG_RESP_OKAY);
        pins(4, RUN_OK);
        for (int a = 0; a < 4; a++) begin
            wr(`OMG_OFS_CTRL, a, `OMG_RESP_OKAY);
            osc_mode <= 2'h1;
            pins(40, {(a == 1) ? 5'h1F : 5'h00, a == 0, 4'h8});
            wr(`OMG_OFS_CTRL, 32'h4, `OMG_RESP_OKAY);
            rd(`OMG_OFS_STATE, 32'h7, a, `OMG_RESP_OKAY);
            osc_mode <= 2'h0;
            pins(30, {(a == 3) ? 5'h00 : 5'h1F, a != 3, 4'h8});
            rd(`OMG_OFS_STATUS, 32'h3, 32'h1, `OMG_RESP_OKAY);
            wr(`OMG_OFS_STATUS, 32'h3, `OMG_RESP_OKAY);
            pins(4, RUN_OK);
        end
        rd(`OMG_OFS_STATE, 32'h7, 32'h4, `OMG_RESP_OKAY);
        osc_mode <= 2'h1;
        pins(40, RUN_OK);
        osc_mode <= 2'h2;
        pins(40, RUN_OK);
        osc_mode <= 2'h0;
        wr(`OMG_OFS_CTRL, 32'h0, `OMG_RESP_OKAY);
        osc_mode <= 2'h2;
        pins(30, {5'h00, 5'h18});
        rd(`OMG_OFS_STATUS, 32'h3, 32'h2, `OMG_RESP_OKAY);
        osc_mode <= 2'h0;
        pins(20, {5'h1F, 5'h18});
        wr(`OMG_OFS_STATUS, 32'h3, `OMG_RESP_OKAY);
        pins(4, RUN_OK);
        close_out();
    end
endmodule

`default_nettype wire
